// *** fsr_shifter.sv ***
// Four-stage shift register covering the plain, sync-load, async-load and scan cells.
// Assumes synchronous inputs, a classic Wishbone master and one 50 MHz clock.
//
// Chosen here: the Wishbone slave port and the address map.

`timescale 1ns/1ns
`default_nettype none

module fsr_shifter
   import fsr_pkg::*;
#(
   parameter int STAGES = fsr_pkg::FSR_STAGES,
   parameter int CNT_W  = fsr_pkg::FSR_CNT_W
) (
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         arst_n,
   // Wishbone slave
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [fsr_pkg::FSR_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   output logic      [31:0]                  wb_dat_o,
   output logic                              wb_ack_o,
   // Serial, clock and load inputs
   input  wire logic                         serial_in,
   input  wire logic                         shift_clock,
   input  wire logic                         load,
   // Parallel inputs
   input  wire logic                         par_in0,
   input  wire logic                         par_in1,
   input  wire logic                         par_in2,
   input  wire logic                         par_in3,
   // Scan test inputs
   input  wire logic                         scan_in,
   input  wire logic                         hold_inhibit,
   input  wire logic                         scan_clk_a,
   input  wire logic                         scan_clk_b,
   // Parallel outputs
   output logic                              stage0_out,
   output logic                              stage1_out,
   output logic                              stage2_out,
   output logic                              stage3_out
);
   import fsr_pkg::*;

   // Refuse sizes the logic cannot serve
   if (STAGES != 4) begin : g_bad_stages
      $error("STAGES must be 4");
   end
   if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
      $error("CNT_W must be 1 to 32");
   end

   logic               sck_fall;
   logic               a_rise;
   logic               b_rise;
   logic [3:0]         par;
   logic [3:0]         shift_word;
   logic [3:0]         scan_word;
   logic [3:0]         stage_r;
   logic [3:0]         stage_nxt;
   logic [3:0]         master_r;
   logic [3:0]         master_nxt;
   logic [CNT_W-1:0]   count_r;
   logic [CNT_W-1:0]   count_nxt;
   logic               moved;
   fsr_variant_t       variant_r;
   fsr_variant_t       variant_nxt;
   logic               ack_r;
   logic               ack_nxt;
   logic [31:0]        dat_r;
   logic [31:0]        dat_nxt;
   logic               req;

   fsr_edges fsr_edges_inst (
      .clock       (clock),
      .arst_n      (arst_n),
      .shift_clock (shift_clock),
      .scan_clk_a  (scan_clk_a),
      .scan_clk_b  (scan_clk_b),
      .sck_fall    (sck_fall),
      .a_rise      (a_rise),
      .b_rise      (b_rise)
   );

   assign par        = {par_in3, par_in2, par_in1, par_in0};
   assign shift_word = {stage_r[2:0], serial_in};
   assign scan_word  = {stage_r[2:0], scan_in};
   assign req        = wb_cyc_i & wb_stb_i & ~ack_r;

   // Stage update per variant
   always_comb begin
      stage_nxt  = stage_r;
      master_nxt = master_r;
      moved      = 1'b0;
      unique case (variant_r)
         FSR_PLAIN: begin
            if (sck_fall) begin
               stage_nxt = shift_word;
               moved     = 1'b1;
            end
         end
         FSR_SYNC_LOAD: begin
            if (sck_fall) begin
               moved = 1'b1;
               if (load) begin
                  stage_nxt = par;
               end else begin
                  stage_nxt = shift_word;
               end
            end
         end
         FSR_ASYNC_LOAD: begin
            if (load) begin
               stage_nxt = par;
            end else if (sck_fall) begin
               stage_nxt = shift_word;
               moved     = 1'b1;
            end
         end
         FSR_SCAN: begin
            if (a_rise) begin
               master_nxt = scan_word;
            end
            if (b_rise) begin
               stage_nxt = master_r;
               moved     = 1'b1;
            end else if (sck_fall && !hold_inhibit) begin
               stage_nxt = shift_word;
               moved     = 1'b1;
            end
         end
      endcase
   end

   // Bus slave and shift counter
   always_comb begin
      variant_nxt = variant_r;
      count_nxt   = count_r;
      ack_nxt     = req;
      dat_nxt     = dat_r;
      if (req && wb_we_i && wb_adr_i == FSR_ADDR_COUNT && wb_sel_i[0]) begin
         count_nxt = '0;
      end
      // Clear first; an event in the same cycle then counts to 1
      if (moved) begin
         count_nxt = CNT_W'(count_nxt + 1'b1);
      end
      if (req && wb_we_i && wb_adr_i == FSR_ADDR_CTRL && wb_sel_i[0]) begin
         variant_nxt = fsr_variant_t'(wb_dat_i[FSR_CTRL_VAR_HI:FSR_CTRL_VAR_LO]);
      end
      if (req && !wb_we_i) begin
         dat_nxt = 32'h0000_0000;
         unique case (wb_adr_i)
            FSR_ADDR_CTRL: begin
               dat_nxt[FSR_CTRL_VAR_HI:FSR_CTRL_VAR_LO] = variant_r;
            end
            FSR_ADDR_STATUS: begin
               dat_nxt[FSR_STAT_STG_HI:FSR_STAT_STG_LO] = stage_r;
               dat_nxt[FSR_STAT_LOAD]                   = load;
               dat_nxt[FSR_STAT_VAR_HI:FSR_STAT_VAR_LO] = variant_r;
            end
            FSR_ADDR_COUNT: begin
               dat_nxt[CNT_W-1:0] = count_r;
            end
            default: begin
               dat_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stage_r   <= FSR_STAGE_RST;
         master_r  <= FSR_STAGE_RST;
         count_r   <= CNT_W'(FSR_COUNT_RST);
         variant_r <= FSR_PLAIN;
         ack_r     <= 1'b0;
         dat_r     <= FSR_DAT_RST;
      end else begin
         stage_r   <= stage_nxt;
         master_r  <= master_nxt;
         count_r   <= count_nxt;
         variant_r <= variant_nxt;
         ack_r     <= ack_nxt;
         dat_r     <= dat_nxt;
      end
   end

   assign stage0_out = stage_r[0];
   assign stage1_out = stage_r[1];
   assign stage2_out = stage_r[2];
   assign stage3_out = stage_r[3];
   assign wb_ack_o   = ack_r;
   assign wb_dat_o   = dat_r;

   sequence s_scan_a_then_b;
      (variant_r == FSR_SCAN && a_rise && !b_rise) ##1
      (variant_r == FSR_SCAN && b_rise && !a_rise);
   endsequence

   sequence s_async_load_held;
      (variant_r == FSR_ASYNC_LOAD && load) [*2];
   endsequence

   AST_PLAIN_SHIFT: assert property (
      @(posedge clock) disable iff (!arst_n)
      (variant_r == FSR_PLAIN && sck_fall) |=>
      ({stage3_out, stage2_out, stage1_out, stage0_out} == $past(shift_word)))
      else $error("plain shift did not move one place");

   AST_PLAIN_HOLD: assert property (
      @(posedge clock) disable iff (!arst_n)
      (variant_r == FSR_PLAIN && !sck_fall && $stable(variant_r)) |=>
      $stable({stage3_out, stage2_out, stage1_out, stage0_out}))
      else $error("outputs changed without a falling edge");

   AST_SYNC_LOAD: assert property (
      @(posedge clock) disable iff (!arst_n)
      (variant_r == FSR_SYNC_LOAD && sck_fall && load) |=>
      (stage_r == $past(par)))
      else $error("sync load did not copy parallel inputs");

   AST_LOAD_ORDER: assert property (
      @(posedge clock) disable iff (!arst_n)
      (variant_r == FSR_SYNC_LOAD && sck_fall && load) |=>
      (stage0_out == $past(par_in0) && stage3_out == $past(par_in3)))
      else $error("parallel input landed in wrong stage");

   AST_SYNC_SHIFT: assert property (
      @(posedge clock) disable iff (!arst_n)
      (variant_r == FSR_SYNC_LOAD && sck_fall && !load) |=>
      (stage_r[3:1] == $past(stage_r[2:0], 1) && stage_r[0] == $past(serial_in)))
      else $error("sync variant did not shift with load low");

   AST_ASYNC_FORCE: assert property (
      @(posedge clock) disable iff (!arst_n)
      s_async_load_held |=> (stage_r == $past(par)))
      else $error("async load did not force stages");

   AST_SCAN_CAPTURE: assert property (
      @(posedge clock) disable iff (!arst_n)
      s_scan_a_then_b |=> (stage_r == $past(scan_word, 2)))
      else $error("scan clocks did not load scan word");

   AST_SCAN_INHIBIT: assert property (
      @(posedge clock) disable iff (!arst_n)
      (variant_r == FSR_SCAN && hold_inhibit && !b_rise && $stable(variant_r)) |=>
      $stable(stage_r))
      else $error("inhibit did not hold stages");

   AST_ASYNC_SHIFT: assert property (
      @(posedge clock) disable iff (!arst_n)
      (variant_r == FSR_ASYNC_LOAD && !load && sck_fall) |=>
      (stage_r == $past(shift_word)))
      else $error("async variant did not shift after release");

   AST_ASYNC_NO_CLOCK: assert property (
      @(posedge clock) disable iff (!arst_n)
      (variant_r == FSR_ASYNC_LOAD && load && sck_fall) |=>
      (stage_r == $past(par)))
      else $error("shift clock disturbed an async load");

   AST_COUNT_STEP: assert property (
      @(posedge clock) disable iff (!arst_n)
      (moved && !(req && wb_we_i && wb_adr_i == FSR_ADDR_COUNT && wb_sel_i[0])) |=>
      (count_r == CNT_W'($past(count_r) + 1'b1)))
      else $error("count did not step on a stage event");

   AST_COUNT_CLEAR: assert property (
      @(posedge clock) disable iff (!arst_n)
      (req && wb_we_i && wb_adr_i == FSR_ADDR_COUNT && wb_sel_i[0] && !moved) |=>
      (count_r == '0))
      else $error("count write did not clear");

   AST_WB_ACK: assert property (
      @(posedge clock) disable iff (!arst_n)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle one edge after request");

endmodule : fsr_shifter

`default_nettype wire

// *** fsr_pkg.sv ***
// Package for the four-stage shift register cell family, plus the input edge detector.
// Assumes every cell input is synchronous to the single system clock.
package fsr_pkg;
   localparam int          FSR_STAGES      = 4;
   localparam int          FSR_CNT_W       = 16;
   localparam int          FSR_ADR_W       = 8;
   // Byte offsets of the Wishbone registers
   localparam logic [7:0]  FSR_ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  FSR_ADDR_STATUS = 8'h04;
   localparam logic [7:0]  FSR_ADDR_COUNT  = 8'h08;
   // Field positions
   localparam int          FSR_CTRL_VAR_LO = 0;
   localparam int          FSR_CTRL_VAR_HI = 1;
   localparam int          FSR_STAT_STG_LO = 0;
   localparam int          FSR_STAT_STG_HI = 3;
   localparam int          FSR_STAT_LOAD   = 4;
   localparam int          FSR_STAT_VAR_LO = 8;
   localparam int          FSR_STAT_VAR_HI = 9;
   // Values after reset
   localparam logic [3:0]  FSR_STAGE_RST   = 4'h0;
   localparam logic [15:0] FSR_COUNT_RST   = 16'h0000;
   localparam logic [31:0] FSR_DAT_RST     = 32'h0000_0000;

   typedef enum logic [1:0] {
      FSR_PLAIN,
      FSR_SYNC_LOAD,
      FSR_ASYNC_LOAD,
      FSR_SCAN
   } fsr_variant_t;
endpackage : fsr_pkg

`timescale 1ns/1ns
`default_nettype none

// Registers previous levels and flags falling and rising edges
module fsr_edges (
   // Clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // Sampled levels
   input  wire logic shift_clock,
   input  wire logic scan_clk_a,
   input  wire logic scan_clk_b,
   // Edge pulses
   output logic      sck_fall,
   output logic      a_rise,
   output logic      b_rise
);
   logic [2:0] prev_r;
   logic [2:0] prev_nxt;

   always_comb begin
      prev_nxt = {scan_clk_b, scan_clk_a, shift_clock};
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prev_r <= 3'h0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   assign sck_fall = prev_r[0] & ~shift_clock;
   assign a_rise   = ~prev_r[1] & scan_clk_a;
   assign b_rise   = ~prev_r[2] & scan_clk_b;
endmodule : fsr_edges

`default_nettype wire

// *** fsr_far_model.sv ***
// Far-side logic model: one shift-clock pulse per requested bit.
// Assumes one system clock; serial data is flipped outside a pulse.
`timescale 1ns/1ns
`default_nettype none
module fsr_far_model (
   // Clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // Request
   input  wire logic go,
   input  wire logic bit_i,
   output logic      busy,
   // Cell drive
   output logic      shift_clock,
   output logic      serial_in
);
   logic [1:0] ph_r;
   assign busy = (ph_r != 2'h0);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ph_r        <= 2'h0;
         shift_clock <= 1'b0;
         serial_in   <= 1'b0;
      end else begin
         ph_r <= (ph_r == 2'h0) ? {1'b0, go} : ph_r + 2'h1;
         if (ph_r == 2'h0 && go) begin
            shift_clock <= 1'b1;
            serial_in   <= bit_i;
         end
         if (ph_r == 2'h1)
            shift_clock <= 1'b0;
         // Stale data must not look valid
         if (ph_r == 2'h3)
            serial_in <= ~serial_in;
      end
   end
endmodule : fsr_far_model
`default_nettype wire

// *** test_fsr_shifter.sv ***
// Testbench for the shift register cells, bus tasks and far-side model.
// Assumes a 50 MHz clock and a one-cycle Wishbone answer.
`timescale 1ns/1ns
`default_nettype none
module test_fsr_shifter;
   import fsr_pkg::*;
   logic        clock, arst_n, cyc, stb, we, ack, go, bit_i, busy;
   logic        sc, si, load, scan_in, ih, sa, sb;
   logic [7:0]  adr;
   logic [3:0]  sel, par, e;
   wire  [3:0]  stg;
   logic [31:0] wdat, rdat, q;
   int          error_cnt, cmp_count;
   always #10 clock = ~clock;
   fsr_shifter fsr_shifter_inst (
      .clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .serial_in(si), .shift_clock(sc),
      .load(load), .par_in0(par[0]), .par_in1(par[1]), .par_in2(par[2]),
      .par_in3(par[3]), .scan_in(scan_in), .hold_inhibit(ih),
      .scan_clk_a(sa), .scan_clk_b(sb), .stage0_out(stg[0]),
      .stage1_out(stg[1]), .stage2_out(stg[2]), .stage3_out(stg[3]));
   fsr_far_model fsr_far_model_inst (
      .clock(clock), .arst_n(arst_n), .go(go), .bit_i(bit_i),
      .busy(busy), .shift_clock(sc), .serial_in(si));
   task automatic wrap_up;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         error_cnt++;
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         wrap_up();
      end
   endtask : wb
   task automatic shift(input logic b);
      int n;
      n = 0;
      @(posedge clock);
      go <= 1'b1;
      bit_i <= b;
      @(posedge clock);
      go <= 1'b0;
      do begin
         @(posedge clock);
         n++;
      end while (busy !== 1'b0 && n < 20);
      @(posedge clock);
      if (n >= 20) begin
         error_cnt++;
         wrap_up();
      end
   endtask : shift
   task automatic pulse_scan(input logic b);
      @(posedge clock);
      if (b) sb <= 1'b1; else sa <= 1'b1;
      @(posedge clock);
      sa <= 1'b0;
      sb <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : pulse_scan
   task automatic scan_pair;
      @(posedge clock);
      sa <= 1'b1;
      @(posedge clock);
      sb <= 1'b1;
      @(posedge clock);
      sa <= 1'b0;
      sb <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : scan_pair
   initial begin
      clock = 0; arst_n = 0; cyc = 0; stb = 0; we = 0; adr = 8'h00;
      sel = 4'h0; wdat = 32'h0; load = 0; par = 4'h0; scan_in = 0;
      ih = 0; sa = 0; sb = 0; go = 0; bit_i = 0;
      error_cnt = 0; cmp_count = 0; e = 4'h0;
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      wb(1'b0, FSR_ADDR_STATUS, 32'h0);
      check(q, 32'h0);
      wb(1'b0, 8'h0C, 32'h0);
      check(q, 32'h0);
      // Plain cell ignores load
      load <= 1'b1;
      par <= 4'hF;
      for (int i = 0; i < 4; i++) begin
         shift(i != 1);
         e = {e[2:0], 1'(i != 1)};
         check(stg, e);
      end
      wb(1'b0, FSR_ADDR_COUNT, 32'h0);
      check(q, 32'h4);
      wb(1'b1, FSR_ADDR_COUNT, 32'h0);
      wb(1'b0, FSR_ADDR_COUNT, 32'h0);
      check(q, 32'h0);
      wb(1'b1, FSR_ADDR_CTRL, 32'h1);
      par <= 4'hA;
      shift(1'b0);
      check(stg, 4'hA);
      wb(1'b0, FSR_ADDR_STATUS, 32'h0);
      check(q, 32'h11A);
      load <= 1'b0;
      shift(1'b1);
      check(stg, 4'h5);
      wb(1'b1, FSR_ADDR_CTRL, 32'h2);
      par <= 4'h6;
      load <= 1'b1;
      repeat (3) @(posedge clock);
      check(stg, 4'h6);
      par <= 4'h9;
      repeat (3) @(posedge clock);
      check(stg, 4'h9);
      shift(1'b1);
      check(stg, 4'h9);
      load <= 1'b0;
      shift(1'b0);
      check(stg, 4'h2);
      wb(1'b1, FSR_ADDR_CTRL, 32'h3);
      wb(1'b0, FSR_ADDR_CTRL, 32'h0);
      check(q, 32'h3);
      ih <= 1'b1;
      shift(1'b1);
      check(stg, 4'h2);
      scan_in <= 1'b1;
      pulse_scan(1'b0);
      pulse_scan(1'b1);
      check(stg, 4'h5);
      // Capture and transfer on back-to-back scan clocks
      scan_in <= 1'b0;
      scan_pair();
      check(stg, 4'hA);
      // Mid-run reset returns stages and variant to idle
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      check(stg, 4'h0);
      wb(1'b0, FSR_ADDR_CTRL, 32'h0);
      check(q, 32'h0);
      wrap_up();
   end
endmodule : test_fsr_shifter
`default_nettype wire
